// *** pmw_map.vh ***
`ifndef PMW_MAP_VH
`define PMW_MAP_VH

// register byte address on the axi4-lite bus
`define PMW_ADDR_PM_CTL 12'h020
// address bits decoded by the slave
`define PMW_ADDR_W 12

// field positions inside power_management_control_low
`define PMW_WAKE_CAUSE_LO 0
`define PMW_WAKE_CAUSE_HI 1
`define PMW_ENERGY_EN_BIT 2
`define PMW_LAN_EN_BIT 3
`define PMW_PHY_RESET_TRIGGER_BIT 4
`define PMW_SUSP_LO 5
`define PMW_SUSP_HI 6
`define PMW_RES_CLR_BIT 9

// reset values
`define PMW_SUSP_RESET 2'h2
`define PMW_WAKE_CAUSE_RESET 2'h0
`define PMW_ENABLE_RESET 1'h0
`define PMW_RES_CLR_RESET 1'h0

// suspend selector encodings
`define PMW_SUSP_ZERO 2'h0
`define PMW_SUSP_ONE 2'h1
`define PMW_SUSP_TWO 2'h2
`define PMW_SUSP_GOOD_FRAME 2'h3

// wake cause encodings
`define PMW_CAUSE_NONE 2'h0
`define PMW_CAUSE_ENERGY 2'h1
`define PMW_CAUSE_LAN 2'h2
`define PMW_CAUSE_MULTI 2'h3

// axi response codes
`define PMW_RESP_OKAY 2'h0
`define PMW_RESP_SLVERR 2'h2

// timing: clock period and least phy reset hold time
`define PMW_CLK_PERIOD_NS 100
`define PMW_PHY_RESET_TRIGGER_MS 2
// least hold time in whole cycles (2 ms at 100 ns), sized to the counter
`define PMW_PHY_RESET_TRIGGER_CYCLES 16'h4E20
// width of the phy reset counter
`define PMW_CNT_W 16

`endif

// *** pmw_ctrl.v ***
`timescale 1ns/100ps
`include "pmw_map.vh"

module pmw_ctrl #(
   parameter [`PMW_CNT_W-1:0] PHY_RESET_TRIGGER_CYCLES = `PMW_PHY_RESET_TRIGGER_CYCLES,
   parameter GOOD_FRAME_SUPPORT = 1
) (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // axi4-lite write address channel
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [`PMW_ADDR_W-1:0] s_axi_awaddr,
   // axi4-lite write data channel
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // axi4-lite write response channel
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   // axi4-lite read address channel
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [`PMW_ADDR_W-1:0] s_axi_araddr,
   // axi4-lite read data channel
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   // device state from the usb side
   input wire dev_deconfig,
   input wire suspend_enter,
   input wire resume_done,
   // wake sources from the ethernet phy and mac
   input wire energy_detect,
   input wire lan_wake_event,
   // power state, phy reset and usb handshake control
   output reg [1:0] suspend_level,
   output reg phy_reset,
   output reg usb_nak_all,
   output reg wake_request
);

   // address match for the single register of this block
   function addr_hit;
      input [`PMW_ADDR_W-1:0] addr;
      begin
         // compare whole byte addresses so both sides have the same width
         addr_hit = ({addr[`PMW_ADDR_W-1:2], 2'b00} == `PMW_ADDR_PM_CTL);
      end
   endfunction

   // maps the software selector to the level actually entered
   function [1:0] susp_map;
      input [1:0] sel;
      begin
         if (sel == `PMW_SUSP_GOOD_FRAME && GOOD_FRAME_SUPPORT == 0) begin
            susp_map = `PMW_SUSP_TWO;
         end else begin
            susp_map = sel;
         end
      end
   endfunction

   // the fields live in separate flops rather than one 32-bit word so that
   // unimplemented bits cost nothing and always read back as zero
   // register fields
   reg [1:0] susp_sel_reg; // suspend selector
   reg [1:0] susp_sel_next;
   reg lan_en_reg; // lan wake enable
   reg lan_en_next;
   reg energy_en_reg; // energy wake enable
   reg energy_en_next;
   reg [1:0] cause_reg; // wake cause, write one to clear
   reg [1:0] cause_next;
   reg res_clr_reg; // resume clears the lan bit of wake status
   reg res_clr_next;

   // phy reset sequencer
   reg phy_busy_reg; // trigger bit as software sees it
   reg [`PMW_CNT_W-1:0] phy_cnt_reg; // cycles left in the reset pulse

   // low power bookkeeping
   reg low_power_reg; // between suspend entry and resume
   reg lan_armed_reg; // lan enable captured at suspend entry
   reg energy_armed_reg; // energy enable captured at suspend entry
   reg remote_wake_reg; // current wake was raised by a recorded event

   // axi write capture
   reg aw_held_reg; // address taken, waiting for data
   reg [`PMW_ADDR_W-1:0] aw_addr_reg;
   reg w_held_reg; // data taken, waiting for address
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // merged view of the write that can commit this cycle
   wire aw_fire = s_axi_awvalid & s_axi_awready;
   wire w_fire = s_axi_wvalid & s_axi_wready;
   wire aw_have = aw_held_reg | aw_fire;
   wire w_have = w_held_reg | w_fire;
   wire [`PMW_ADDR_W-1:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
   wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
   wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
   wire wr_commit = aw_have & w_have & ~s_axi_bvalid;
   wire wr_hit = wr_commit & addr_hit(wr_addr);
   // byte lanes carrying the fields
   wire wr_lane0 = wr_hit & wr_strb[0];
   wire wr_lane1 = wr_hit & wr_strb[1];

   // qualified wake events while in the reduced power state
   wire energy_evt = low_power_reg & energy_armed_reg & energy_detect;
   wire lan_evt = low_power_reg & lan_armed_reg & lan_wake_event;
   wire [1:0] cause_set = {lan_evt, energy_evt};

   // phy reset start: a write of one is honoured only when idle
   wire phy_start = wr_lane0 & wr_data[`PMW_PHY_RESET_TRIGGER_BIT] & ~phy_busy_reg;

   // value the trigger bit takes at the next edge; the phy reset line and
   // the nak flag follow this so that all three drop in the same edge and
   // the bit never reads low while the phy is still held
   wire phy_cnt_done = (phy_cnt_reg == {`PMW_CNT_W{1'b0}});
   wire phy_busy_next = phy_start | (phy_busy_reg & ~phy_cnt_done);

   // the order of the statements below sets the priorities: write, then
   // resume-clear, then new events, then deconfiguration of the selector
   // next value of the software fields
   always @* begin
      susp_sel_next = susp_sel_reg;
      lan_en_next = lan_en_reg;
      energy_en_next = energy_en_reg;
      res_clr_next = res_clr_reg;
      cause_next = cause_reg;
      if (wr_lane0) begin
         // the host keeps the selector at level two while unconfigured
         susp_sel_next = wr_data[`PMW_SUSP_HI:`PMW_SUSP_LO];
         lan_en_next = wr_data[`PMW_LAN_EN_BIT];
         energy_en_next = wr_data[`PMW_ENERGY_EN_BIT];
         // either cause bit written as one clears the whole field
         if (|wr_data[`PMW_WAKE_CAUSE_HI:`PMW_WAKE_CAUSE_LO]) begin
            cause_next = `PMW_CAUSE_NONE;
         end
      end
      if (wr_lane1) begin
         res_clr_next = wr_data[`PMW_RES_CLR_BIT];
      end
      // remote-initiated resume drops the lan bit when enabled
      if (resume_done & res_clr_reg & remote_wake_reg) begin
         cause_next[`PMW_WAKE_CAUSE_HI] = 1'b0;
      end
      // a new event wins over any clear in the same cycle; or-ing
      // energy and lan bits yields 11 when both have occurred
      cause_next = cause_next | cause_set;
      // deconfiguration overrides any write to the selector
      if (dev_deconfig) begin
         susp_sel_next = `PMW_SUSP_RESET;
      end
   end

   // every field returns to its reset value on reset; the selector resets
   // to level two, the only level valid while unconfigured
   // register field storage
   always @(posedge ref_clk) begin
      if (rst) begin
         susp_sel_reg <= `PMW_SUSP_RESET;
         lan_en_reg <= `PMW_ENABLE_RESET;
         energy_en_reg <= `PMW_ENABLE_RESET;
         cause_reg <= `PMW_WAKE_CAUSE_RESET;
         res_clr_reg <= `PMW_RES_CLR_RESET;
      end else begin
         susp_sel_reg <= susp_sel_next;
         lan_en_reg <= lan_en_next;
         energy_en_reg <= energy_en_next;
         cause_reg <= cause_next;
         res_clr_reg <= res_clr_next;
      end
   end

   // the pulse length is a parameter: the default gives the full hold time,
   // a bench may shorten it; software cannot cut it short because a start
   // is only accepted while the sequencer is idle
   // phy reset sequencer: counts the hold time down, then releases
   always @(posedge ref_clk) begin
      if (rst) begin
         phy_busy_reg <= 1'b0;
         phy_cnt_reg <= {`PMW_CNT_W{1'b0}};
      end else if (phy_start) begin
         phy_busy_reg <= 1'b1;
         phy_cnt_reg <= PHY_RESET_TRIGGER_CYCLES - 16'h0001;
      end else if (phy_busy_reg) begin
         if (phy_cnt_reg == {`PMW_CNT_W{1'b0}}) begin
            // bit drops in the same edge that releases the phy
            phy_busy_reg <= 1'b0;
         end else begin
            phy_cnt_reg <= phy_cnt_reg - 16'h0001;
         end
      end
   end

   // limitation: an event in the very cycle of suspend entry is not recorded,
   // because the armed copies only take effect from the next edge
   // low power tracking; enables are sampled at entry so a late enable
   // cannot turn an already pending line event into a wake cause
   always @(posedge ref_clk) begin
      if (rst) begin
         low_power_reg <= 1'b0;
         lan_armed_reg <= 1'b0;
         energy_armed_reg <= 1'b0;
         remote_wake_reg <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         if (suspend_enter) begin
            low_power_reg <= 1'b1;
            lan_armed_reg <= lan_en_reg;
            energy_armed_reg <= energy_en_reg;
            remote_wake_reg <= 1'b0;
         end else if (resume_done) begin
            low_power_reg <= 1'b0;
            remote_wake_reg <= 1'b0;
         end else if (|cause_set) begin
            remote_wake_reg <= 1'b1;
         end
         // wake request stands from the first event until the resume or the next suspend entry
         if (resume_done | suspend_enter) begin
            wake_request <= 1'b0;
         end else if (|cause_set) begin
            wake_request <= 1'b1;
         end
      end
   end

   // outputs toward the power, phy and usb logic
   always @(posedge ref_clk) begin
      if (rst) begin
         suspend_level <= `PMW_SUSP_RESET;
         phy_reset <= 1'b0;
         usb_nak_all <= 1'b0;
      end else begin
         suspend_level <= susp_map(susp_sel_next);
         // both track the trigger bit edge for edge, so software never sees
         // the bit clear while the phy is still held or the usb side naks
         phy_reset <= phy_busy_next;
         usb_nak_all <= phy_busy_next;
      end
   end

   // hazard avoided: the field update and bvalid come from the same commit
   // term, so a write is never answered without having taken effect, and
   // no second write is taken while the response still stands
   // axi write channels: each side is taken on its own, the
   // response follows once both are in hand
   always @(posedge ref_clk) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `PMW_RESP_OKAY;
         aw_held_reg <= 1'b0;
         aw_addr_reg <= {`PMW_ADDR_W{1'b0}};
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end else begin
         if (aw_fire) begin
            s_axi_awready <= 1'b0;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (w_fire) begin
            s_axi_wready <= 1'b0;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_commit) begin
            // the write takes effect now; answer on the next edge
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_hit(wr_addr) ? `PMW_RESP_OKAY : `PMW_RESP_SLVERR;
         end else begin
            if (aw_fire) begin
               aw_held_reg <= 1'b1;
            end
            if (w_fire) begin
               w_held_reg <= 1'b1;
            end
         end
         if (s_axi_bvalid & s_axi_bready) begin
            // reopen both channels only after the response is gone
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // read data is a snapshot at the address edge; it stands unchanged until
   // the master takes it even if the fields move meanwhile
   // axi read: one outstanding read, data one cycle after address
   always @(posedge ref_clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `PMW_RESP_OKAY;
      end else begin
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h00000000;
            if (addr_hit(s_axi_araddr)) begin
               s_axi_rresp <= `PMW_RESP_OKAY;
               // unused and reserved bits read as zero
               s_axi_rdata[`PMW_RES_CLR_BIT] <= res_clr_reg;
               s_axi_rdata[`PMW_SUSP_HI:`PMW_SUSP_LO] <= susp_sel_reg;
               s_axi_rdata[`PMW_PHY_RESET_TRIGGER_BIT] <= phy_busy_reg;
               s_axi_rdata[`PMW_LAN_EN_BIT] <= lan_en_reg;
               s_axi_rdata[`PMW_ENERGY_EN_BIT] <= energy_en_reg;
               s_axi_rdata[`PMW_WAKE_CAUSE_HI:`PMW_WAKE_CAUSE_LO] <= cause_reg;
            end else begin
               s_axi_rresp <= `PMW_RESP_SLVERR;
            end
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // pmw_ctrl

// *** pmw_chk.sv ***
`timescale 1ns/100ps
`include "pmw_map.vh"
// port-level watcher for the power management block
module pmw_chk #(
   parameter int PHY_RESET_TRIGGER_CYCLES = 20000
) (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // bus answers
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_rvalid,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   // usb and phy side
   input wire dev_deconfig,
   input wire resume_done,
   input wire energy_detect,
   input wire lan_wake_event,
   input wire [1:0] suspend_level,
   input wire phy_reset,
   input wire usb_nak_all,
   input wire wake_request
);
   // cycles the phy has spent in reset so far
   int hold_cnt;
   // any wake source this cycle
   wire any_wake = energy_detect | lan_wake_event;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // restarts whenever the phy is out of reset
   always @(posedge ref_clk) begin
      if (rst || !phy_reset) begin
         hold_cnt <= 0;
      end else begin
         hold_cnt <= hold_cnt + 1;
      end
   end
   chk_nak_tracks_phy:
      assert property (usb_nak_all == phy_reset) else $error("nak flag differs from phy reset");
   // a restart would stretch the pulse, so the exact length also guards writes in flight
   chk_phy_hold_exact:
      assert property ($fell(phy_reset) && !$past(rst) |-> hold_cnt == PHY_RESET_TRIGGER_CYCLES)
         else $error("phy reset pulse has the wrong length");
   chk_phy_from_write:
      assert property ($rose(phy_reset) |-> s_axi_bvalid || $past(s_axi_bvalid))
         else $error("phy reset rose without a register write");
   chk_deconfig_level:
      assert property (dev_deconfig |-> ##2 suspend_level == 2'h2)
         else $error("deconfigure did not restore level two");
   chk_wake_has_source:
      assert property ($rose(wake_request) |-> $past(any_wake))
         else $error("wake request without a wake source");
   chk_resume_drops_req:
      assert property (resume_done |=> !wake_request) else $error("wake request kept after resume");
   chk_level_readback:
      assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[6:5] == suspend_level)
         else $error("level output differs from selector");
   chk_bresp_stands:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
         else $error("write response dropped before acceptance");
endmodule // pmw_chk

bind pmw_ctrl pmw_chk #(.PHY_RESET_TRIGGER_CYCLES(PHY_RESET_TRIGGER_CYCLES)) pmw_chk_i (.ref_clk, .rst,
   .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
   .dev_deconfig, .resume_done, .energy_detect, .lan_wake_event, .suspend_level, .phy_reset,
   .usb_nak_all, .wake_request);

// *** pmw_far_model.sv ***
`timescale 1ns/100ps
// usb device state strobes and ethernet wake sources
module pmw_far_model (
   // clock
   input wire ref_clk,
   // usb state strobes
   output logic dev_deconfig,
   output logic suspend_enter,
   output logic resume_done,
   // phy wake sources
   output logic energy_detect,
   output logic lan_wake_event
);
   // all quiet at time zero
   initial begin
      {dev_deconfig, suspend_enter, resume_done, energy_detect, lan_wake_event} = 5'h00;
   end
   // one-cycle strobe, then a quiet edge so the block settles before the next access
   task automatic strobe(input logic [4:0] v);
      @(posedge ref_clk);
      {dev_deconfig, suspend_enter, resume_done, energy_detect, lan_wake_event} <= v;
      @(posedge ref_clk);
      {dev_deconfig, suspend_enter, resume_done, energy_detect, lan_wake_event} <= 5'h00;
      @(posedge ref_clk);
   endtask
endmodule // pmw_far_model

// *** pmw_tb.sv ***
`timescale 1ns/100ps
`include "pmw_map.vh"
// register-level bench for the power management block
module tb;
   // register address, a hole beside it, and a short phy hold
   localparam [11:0] PM = `PMW_ADDR_PM_CTL;
   localparam [11:0] HOLE = 12'h024;
   localparam [15:0] HOLD = 16'h0008;
   localparam [1:0] OK = `PMW_RESP_OKAY;
   localparam [1:0] ERR = `PMW_RESP_SLVERR;
   // far side strobe codes
   localparam [4:0] DECONF = 5'h10;
   localparam [4:0] SUSP = 5'h08;
   localparam [4:0] RESUME = 5'h04;
   localparam [4:0] ENERGY = 5'h02;
   localparam [4:0] LAN = 5'h01;
   logic ref_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, suspend_level;
   wire [31:0] s_axi_rdata;
   wire dev_deconfig, suspend_enter, resume_done, energy_detect, lan_wake_event;
   wire phy_reset, usb_nak_all, wake_request;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   pmw_ctrl #(.PHY_RESET_TRIGGER_CYCLES(HOLD), .GOOD_FRAME_SUPPORT(1)) pmw_ctrl_i (.ref_clk, .rst,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .dev_deconfig, .suspend_enter, .resume_done,
      .energy_detect, .lan_wake_event, .suspend_level, .phy_reset, .usb_nak_all, .wake_request);
   pmw_far_model pmw_far_model_i (.ref_clk, .dev_deconfig, .suspend_enter, .resume_done,
      .energy_detect, .lan_wake_event);
   // count one comparison, report a mismatch at once
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one write; bready comes a cycle late so the response has to stand
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
         input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge ref_clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      @(posedge ref_clk);
      s_axi_bready <= 1'b1;
      do @(posedge ref_clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cmp({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   // one read, data and response checked
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge ref_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata, ed);
      cmp({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // counts and verdict, then stop
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // watchdog far above the hundred or so cycles the sequence needs
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // main sequence
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'h0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      rd(PM, 32'h00000040, OK);
      wr(HOLE, 32'h00000000, 4'hF, ERR);
      rd(HOLE, 32'h00000000, ERR);
      for (int i = 0; i < 4; i++) begin
         wr(PM, 32'(i) << 5, 4'h1, OK);
         rd(PM, 32'(i) << 5, OK);
         cmp({30'h0, suspend_level}, 32'(i));
      end
      pmw_far_model_i.strobe(DECONF);
      rd(PM, 32'h00000040, OK);
      wr(PM, 32'h00000050, 4'h1, OK);
      rd(PM, 32'h00000050, OK);
      cmp({30'h0, phy_reset, usb_nak_all}, 32'h00000003);
      wr(PM, 32'h00000050, 4'h1, OK);
      while (phy_reset) @(posedge ref_clk);
      rd(PM, 32'h00000040, OK);
      // energy enabled before suspend, lan not
      wr(PM, 32'h00000044, 4'h1, OK);
      pmw_far_model_i.strobe(SUSP);
      pmw_far_model_i.strobe(ENERGY | LAN);
      rd(PM, 32'h00000045, OK);
      cmp({31'h0, wake_request}, 32'h00000001);
      wr(PM, 32'h00000046, 4'h1, OK);
      rd(PM, 32'h00000044, OK);
      wr(PM, 32'h0000004C, 4'h1, OK);
      pmw_far_model_i.strobe(LAN);
      rd(PM, 32'h0000004C, OK);
      pmw_far_model_i.strobe(RESUME);
      pmw_far_model_i.strobe(SUSP);
      pmw_far_model_i.strobe(ENERGY | LAN);
      pmw_far_model_i.strobe(RESUME);
      rd(PM, 32'h0000004F, OK);
      wr(PM, 32'h00000200, 4'h2, OK);
      rd(PM, 32'h0000024F, OK);
      pmw_far_model_i.strobe(SUSP);
      pmw_far_model_i.strobe(RESUME);
      rd(PM, 32'h0000024F, OK);
      pmw_far_model_i.strobe(SUSP);
      pmw_far_model_i.strobe(LAN);
      pmw_far_model_i.strobe(RESUME);
      rd(PM, 32'h0000024D, OK);
      report_and_stop();
   end
endmodule // tb
